// >>> rtl/restart_master.sv
// Two-wire master: Repeated Start sequence, clock stretching, arbitration.
// Assumes an APB master on pclk and open-drain pads resolved outside.
//
// Overview of operation
// - Restart request while idle pulls the clock line low.
// - Clock seen low: load baud counter, release data for one period.
// - Counter expiry with data high releases the clock line.
// - Clock seen high: reload counter, both lines high one period.
// - Then data low one period with clock high, then clock low.
// - Sequence end clears request, stops counter, data stays low.
// - Start-detected flag set as soon as a Start is seen.
// - Interrupt flag waits until the final counter timeout.
// - Restart request written during other bus activity is ignored.
// - Collision if data low when clock rises in the sequence.
// - Collision if clock falls before we pull data low.
// - Lines are only pulled low or released, never driven high.
// - Released clock still low means wait for the slave.
// - Track Start and Stop; start nothing while the bus is busy and not ours.
// - Data mismatch against sent level loses arbitration, release data.
// - Loser also releases clock and waits for Stop before retrying.
// - With no mismatch the transfer continues unchanged.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
module restart_master
   import restart_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_clock_line_in,
   output logic serial_clock_line_out,
   output logic serial_clock_line_oe,
   input wire logic serial_data_line_in,
   output logic serial_data_line_out,
   output logic serial_data_line_oe,
   output logic irq
);
   state_s r, nxt;
   logic clk_s;
   logic dat_s;
   logic wr;
   logic rd;
   logic hit;
   logic start_cond;
   logic stop_cond;
   logic brg_done;
   logic coll;
   logic restart_ok;
   logic [13:0] a;

   // ==========================================================
   // Combinational next state
   // ==========================================================
   always_comb begin
      nxt = r;

      // ==========================================================
      // Pad synchronisers and edge history
      // ==========================================================
      // Only the second stage of each synchroniser feeds the logic
      nxt.clk_sync = {r.clk_sync[0], serial_clock_line_in};
      nxt.dat_sync = {r.dat_sync[0], serial_data_line_in};
      clk_s = r.clk_sync[1];
      dat_s = r.dat_sync[1];
      nxt.clk_prev = clk_s;
      nxt.dat_prev = dat_s;

      // ==========================================================
      // APB decode
      // ==========================================================
      a = paddr[13:0];
      wr = psel && penable && pwrite && r.pready;
      rd = psel && !penable && !pwrite;
      hit = 1'b1;
      coll = 1'b0;
      restart_ok = 1'b0;

      // ==========================================================
      // Bus conditions and baud counter
      // ==========================================================
      // Start: data falls while clock high; Stop: data rises while clock high
      start_cond = r.dat_prev && !dat_s && clk_s && r.clk_prev;
      stop_cond = !r.dat_prev && dat_s && clk_s && r.clk_prev;
      // The counter runs down to zero and rests there until reloaded
      brg_done = (r.brg == 8'h00);
      if (!brg_done) begin
         nxt.brg = r.brg - 8'h01;
      end

      // ==========================================================
      // Bus monitor
      // ==========================================================
      if (start_cond) begin
         nxt.bus_busy = 1'b1;
         nxt.status[START_SEEN_BIT] = 1'b1;
         nxt.status[STOP_SEEN_BIT] = 1'b0;
      end

      if (stop_cond) begin
         nxt.bus_busy = 1'b0;
         nxt.lost = 1'b0;
         nxt.status[STOP_SEEN_BIT] = 1'b1;
         nxt.status[START_SEEN_BIT] = 1'b0;
      end

      // ==========================================================
      // Sequencer; the pads are only ever pulled low or released
      // ==========================================================
      // Every timed step reloads the counter and waits for it to reach zero;
      // a step that waits on a line level waits as long as the line is held
      case (r.state)
         ST_IDLE: begin
            if (r.ctrl_two[RESTART_BIT]) begin
               nxt.scl_oe = 1'b1;
               nxt.state = ST_CLK_LOW;
            end
         end

         ST_CLK_LOW: begin
            // Wait until the pulled clock is really seen low
            if (!clk_s) begin
               nxt.brg = r.baud;
               nxt.sda_oe = 1'b0;
               nxt.state = ST_DATA_HIGH;
            end
         end

         ST_DATA_HIGH: begin
            if (brg_done && r.scl_oe) begin
               if (dat_s) begin
                  nxt.scl_oe = 1'b0;
               end else begin
                  coll = 1'b1;
               end
            end else if (!r.scl_oe && clk_s) begin
               // Clock only counts as high once the slave lets go
               if (!dat_s) begin
                  coll = 1'b1;
               end else begin
                  nxt.brg = r.baud;
                  nxt.state = ST_BOTH_HIGH;
               end
            end
         end

         ST_BOTH_HIGH: begin
            // Both lines must stay high for the whole period
            if (!clk_s || !dat_s) begin
               coll = 1'b1;
            end else if (brg_done) begin
               nxt.sda_oe = 1'b1;
               nxt.brg = r.baud;
               nxt.state = ST_DATA_LOW;
            end
         end

         ST_DATA_LOW: begin
            // A clock seen low here was pulled by another master
            if (!clk_s) begin
               coll = 1'b1;
            end else if (brg_done) begin
               nxt.scl_oe = 1'b1;
               nxt.state = ST_FINISH;
            end
         end

         ST_FINISH: begin
            // No reload: counter stays at zero, data held low
            nxt.ctrl_two[RESTART_BIT] = 1'b0;
            nxt.evt_stat[EVT_IRQ_BIT] = 1'b1;
            nxt.state = ST_IDLE;
         end

         default: begin
            nxt.state = ST_IDLE;
         end
      endcase

      // ==========================================================
      // Collision abort
      // ==========================================================
      // Both lines are let go at once so the winning frame is not disturbed
      if (coll) begin
         nxt.scl_oe = 1'b0;
         nxt.sda_oe = 1'b0;
         // Stays off the bus until a Stop is seen
         nxt.lost = 1'b1;
         nxt.brg = 8'h00;
         nxt.ctrl_two[RESTART_BIT] = 1'b0;
         nxt.evt_stat[EVT_COLL_BIT] = 1'b1;
         nxt.evt_stat[EVT_LOST_BIT] = 1'b1;
         nxt.ctrl_one[7] = 1'b1;
         nxt.state = ST_IDLE;
      end

      // ==========================================================
      // APB slave: no wait states, reads captured in setup
      // ==========================================================
      nxt.pready = psel && !penable;
      if (rd) begin
         nxt.prdata = 32'h0000_0000;
         case (a)
            CTRL_TWO_ADDR: begin
               nxt.prdata[7:0] = r.ctrl_two;
            end
            CTRL_ONE_ADDR: begin
               nxt.prdata[7:0] = r.ctrl_one;
            end
            STATUS_ADDR: begin
               nxt.prdata[7:0] = r.status;
            end
            BAUD_ADDR: begin
               nxt.prdata[7:0] = r.baud;
            end
            BUF_ADDR: begin
               nxt.prdata[7:0] = r.buffer;
            end
            MASK_ADDR: begin
               nxt.prdata[7:0] = r.addr_mask;
            end
            CTRL_THREE_ADDR: begin
               nxt.prdata[7:0] = r.ctrl_three;
            end
            EVT_STAT_ADDR: begin
               nxt.prdata[2:0] = r.evt_stat;
            end
            EVT_MASK_ADDR: begin
               nxt.prdata[2:0] = r.evt_mask;
            end
            default: begin
               hit = 1'b0;
            end
         endcase
      end

      // Restart only from an idle sequencer with the bus free or already ours,
      // and never while a lost arbitration still waits for its Stop
      restart_ok = (r.state == ST_IDLE) && !r.ctrl_two[RESTART_BIT] && !r.lost && !coll
         && (!r.bus_busy || r.scl_oe);

      if (wr) begin
         case (a)
            CTRL_TWO_ADDR: begin
               nxt.ctrl_two[7:2] = pwdata[7:2];
               nxt.ctrl_two[0] = pwdata[0];
               if (pwdata[RESTART_BIT] && restart_ok) begin
                  nxt.ctrl_two[RESTART_BIT] = 1'b1;
               end
            end
            CTRL_ONE_ADDR: begin
               nxt.ctrl_one = pwdata[7:0];
            end
            BAUD_ADDR: begin
               nxt.baud = pwdata[7:0];
            end
            BUF_ADDR: begin
               nxt.buffer = pwdata[7:0];
            end
            MASK_ADDR: begin
               nxt.addr_mask = pwdata[7:0];
            end
            CTRL_THREE_ADDR: begin
               nxt.ctrl_three = pwdata[7:0];
            end
            EVT_STAT_ADDR: begin
               // Hardware set this cycle wins over the clear
               nxt.evt_stat = nxt.evt_stat & ~(pwdata[2:0] & ~(nxt.evt_stat & ~r.evt_stat));
            end
            EVT_MASK_ADDR: begin
               nxt.evt_mask = pwdata[2:0];
            end
            default: begin
               hit = 1'b0;
            end
         endcase
      end

      // ==========================================================
      // Interrupt and response
      // ==========================================================
      nxt.irq = |(nxt.evt_stat & r.evt_mask);
      // Every access completes without error
      pslverr = 1'b0;
      if (!hit) begin
         nxt.prdata = 32'h0000_0000;
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{
            clk_sync: 2'b11,
            dat_sync: 2'b11,
            clk_prev: 1'b1,
            dat_prev: 1'b1,
            bus_busy: 1'b0,
            lost: 1'b0,
            state: ST_IDLE,
            brg: 8'h00,
            ctrl_two: CTRL_RST,
            ctrl_one: CTRL_RST,
            ctrl_three: CTRL_RST,
            status: CTRL_RST,
            baud: BAUD_RST,
            buffer: 8'h00,
            addr_mask: MASK_RST,
            evt_stat: 3'h0,
            evt_mask: 3'h0,
            scl_oe: 1'b0,
            sda_oe: 1'b0,
            irq: 1'b0,
            pready: 1'b0,
            prdata: 32'h0000_0000
         };
      end else begin
         r <= nxt;
      end
   end

   // ==========================================================
   // Outputs, all from the state register except pslverr and the constant-low line levels
   // ==========================================================
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign serial_clock_line_out = 1'b0;
   assign serial_clock_line_oe = r.scl_oe;
   assign serial_data_line_out = 1'b0;
   assign serial_data_line_oe = r.sda_oe;
   assign irq = r.irq;
endmodule : restart_master

// >>> rtl/restart_pkg.sv
// Package: register map, field positions, reset values and state codes
// for the two-wire master restart and arbitration block.
// Assumes a 32-bit APB slave with one register per aligned word.
package restart_pkg;
   // ==========================================================
   // Register indices and byte addresses
   // ==========================================================
   localparam logic [11:0] CTRL_TWO_IDX = 12'hfc5;
   localparam logic [11:0] CTRL_ONE_IDX = 12'hfc6;
   localparam logic [11:0] STATUS_IDX = 12'hfc7;
   localparam logic [11:0] BAUD_IDX = 12'hfc8;
   localparam logic [11:0] BUF_IDX = 12'hfc9;
   localparam logic [11:0] MASK_IDX = 12'hfca;
   localparam logic [11:0] CTRL_THREE_IDX = 12'hfcb;
   localparam logic [11:0] EVT_STAT_IDX = 12'hfd0;
   localparam logic [11:0] EVT_MASK_IDX = 12'hfd1;
   localparam logic [13:0] CTRL_TWO_ADDR = {CTRL_TWO_IDX, 2'b00};
   localparam logic [13:0] CTRL_ONE_ADDR = {CTRL_ONE_IDX, 2'b00};
   localparam logic [13:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
   localparam logic [13:0] BAUD_ADDR = {BAUD_IDX, 2'b00};
   localparam logic [13:0] BUF_ADDR = {BUF_IDX, 2'b00};
   localparam logic [13:0] MASK_ADDR = {MASK_IDX, 2'b00};
   localparam logic [13:0] CTRL_THREE_ADDR = {CTRL_THREE_IDX, 2'b00};
   localparam logic [13:0] EVT_STAT_ADDR = {EVT_STAT_IDX, 2'b00};
   localparam logic [13:0] EVT_MASK_ADDR = {EVT_MASK_IDX, 2'b00};
   // ==========================================================
   // Reset values and fields
   // ==========================================================
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] BAUD_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'hff;
   localparam int RESTART_BIT = 1;
   localparam int STOP_SEEN_BIT = 4;
   localparam int START_SEEN_BIT = 3;
   localparam int EVT_IRQ_BIT = 0;
   localparam int EVT_COLL_BIT = 1;
   localparam int EVT_LOST_BIT = 2;
   localparam int SYNC_DEPTH = 2;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_CLK_LOW = 6'b000010,
      ST_DATA_HIGH = 6'b000100,
      ST_BOTH_HIGH = 6'b001000,
      ST_DATA_LOW = 6'b010000,
      ST_FINISH = 6'b100000
   } rs_state_e;

   typedef struct packed {
      logic [1:0] clk_sync;
      logic [1:0] dat_sync;
      logic clk_prev;
      logic dat_prev;
      logic bus_busy;
      logic lost;
      rs_state_e state;
      logic [7:0] brg;
      logic [7:0] ctrl_two;
      logic [7:0] ctrl_one;
      logic [7:0] ctrl_three;
      logic [7:0] status;
      logic [7:0] baud;
      logic [7:0] buffer;
      logic [7:0] addr_mask;
      logic [2:0] evt_stat;
      logic [2:0] evt_mask;
      logic scl_oe;
      logic sda_oe;
      logic irq;
      logic pready;
      logic [31:0] prdata;
   } state_s;
endpackage : restart_pkg

// >>> tb/restart_properties.sv
// Checker: port-level timing of the restart master.
// Assumes it is bound onto every restart_master instance.
`timescale 1ns/100ps
module restart_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic serial_clock_line_in,
   input wire logic serial_clock_line_out,
   input wire logic serial_clock_line_oe,
   input wire logic serial_data_line_out,
   input wire logic serial_data_line_oe
);
   // ==========================================================
   // Bus and line properties
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_setup: assert property (psel && !penable |=> pready) else $error("no pready");
   a_ready_single: assert property (pready |=> !pready) else $error("long pready");
   a_open_drain: assert property (!serial_clock_line_out && !serial_data_line_out)
      else $error("line driven high");
   a_data_fall: assert property ($rose(serial_data_line_oe) |->
      serial_clock_line_in && !serial_clock_line_oe) else $error("data pulled, clock low");
   a_held_low: assert property ($rose(serial_clock_line_oe) && serial_data_line_oe
      |=> serial_data_line_oe [*4]) else $error("data not held");
   a_clock_release: assert property ($fell(serial_clock_line_oe) |->
      !serial_data_line_oe) else $error("clock freed, data held");
   a_abort_both: assert property ($fell(serial_data_line_oe) |->
      !serial_clock_line_oe || $past(serial_clock_line_oe)) else $error("clock held after abort");
   a_stretch_hold: assert property (!serial_clock_line_oe && !serial_clock_line_in
      && !serial_data_line_oe |=> !serial_data_line_oe) else $error("no stretch wait");
endmodule : restart_properties
bind restart_master restart_properties u_restart_properties (.pclk, .presetn, .psel,
   .penable, .pready, .serial_clock_line_in, .serial_clock_line_out, .serial_clock_line_oe,
   .serial_data_line_out, .serial_data_line_oe);

// >>> tb/bus_partner.sv
// Far side: pull-ups, a slave that stretches the clock, a rival master.
// Assumes enables mean pull low; released lines float high.
`timescale 1ns/100ps
module bus_partner (
   input wire logic pclk,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic [7:0] stretch,
   input wire logic rival_low,
   output logic scl,
   output logic sda
);
   logic prev_r = 1'h0;
   logic [7:0] hold_r = 8'h00;
   // ==========================================================
   // Slave keeps the clock low for a while after the master lets go
   always @(posedge pclk) begin
      prev_r <= scl_oe;
      if (prev_r && !scl_oe)
         hold_r <= stretch;
      else if (hold_r != 8'h00)
         hold_r <= hold_r - 8'h01;
   end
   // Wired-and: any party pulling low wins
   assign scl = !(scl_oe || hold_r != 8'h00 || (prev_r && !scl_oe && stretch != 8'h00));
   assign sda = !(sda_oe || rival_low);
endmodule : bus_partner

// >>> tb/restart_master_tb.sv
// Testbench: registers, restart with and without stretching, collision.
// Assumes restart_pkg, restart_master and bus_partner are compiled first.
`timescale 1ns/100ps
module restart_master_tb
   import restart_pkg::*;
;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic rival = 1'h0, pready, pslverr, irq, scl, sda, scl_out, scl_oe, sda_out, sda_oe;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
   logic [7:0] stretch = 8'h00;
   int err_total = 0, total_checks = 0;
   restart_master u_restart_master (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .serial_clock_line_in(scl),
      .serial_clock_line_out(scl_out), .serial_clock_line_oe(scl_oe),
      .serial_data_line_in(sda), .serial_data_line_out(sda_out),
      .serial_data_line_oe(sda_oe), .irq);
   bus_partner u_bus_partner (.pclk, .scl_oe, .sda_oe, .stretch, .rival_low(rival), .scl, .sda);
   always #5 pclk = ~pclk;
   // ==========================================================
   // Shared tasks
   task conclude;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t %s", $time, m);
      end
   endtask : chk
   task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {18'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      q = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 20) begin
         chk(1'h0, 1'h1, "no pready");
         conclude();
      end
   endtask : apb
   task rd(input logic [13:0] a, input logic [31:0] e, input string m);
      apb(1'h0, a, 32'h0);
      chk(q, e, m);
   endtask : rd
   task poll(input logic [13:0] a, input logic [31:0] m, input logic [31:0] v);
      int n;
      n = 0;
      do begin
         apb(1'h0, a, 32'h0);
         n++;
      end while ((q & m) !== v && n < 100);
      if ((q & m) !== v) begin
         chk(1'h0, 1'h1, "poll timeout");
         conclude();
      end
   endtask : poll
   // ==========================================================
   // Scenarios
   task t_regs;
      logic [13:0] a [8];
      a = '{CTRL_TWO_ADDR, CTRL_ONE_ADDR, STATUS_ADDR, BAUD_ADDR, MASK_ADDR, CTRL_THREE_ADDR,
         EVT_STAT_ADDR, EVT_MASK_ADDR};
      foreach (a[i])
         rd(a[i], {24'h0, (i == 4) ? 8'hff : 8'h00}, "reset value");
      apb(1'h1, BAUD_ADDR, 32'h5a);
      rd(BAUD_ADDR, 32'h5a, "baud rw");
      apb(1'h1, 14'h3f00, 32'hff);
      rd(14'h3f00, 32'h0, "unmapped");
      $display("test regs done");
   endtask : t_regs
   task t_restart(input logic [7:0] s);
      stretch <= s;
      apb(1'h1, BAUD_ADDR, 32'h3);
      apb(1'h1, EVT_MASK_ADDR, 32'h1);
      apb(1'h1, CTRL_TWO_ADDR, 32'h2);
      rd(CTRL_TWO_ADDR, 32'h2, "restart bit");
      chk(scl_oe, 1'h1, "clock not pulled");
      chk(irq, 1'h0, "irq early");
      poll(CTRL_TWO_ADDR, 32'h2, 32'h0);
      rd(EVT_STAT_ADDR, 32'h1, "done event");
      chk(irq, 1'h1, "no irq");
      apb(1'h0, STATUS_ADDR, 32'h0);
      chk(q[START_SEEN_BIT], 1'h1, "start flag");
      chk({scl_oe, sda_oe}, 2'h3, "lines not held");
      apb(1'h1, EVT_STAT_ADDR, 32'h1);
      rd(EVT_STAT_ADDR, 32'h0, "clear event");
      chk(irq, 1'h0, "irq stuck");
      $display("test restart done");
   endtask : t_restart
   task t_collide;
      stretch <= 8'h00;
      rival <= 1'h1;
      apb(1'h1, EVT_MASK_ADDR, 32'h7);
      apb(1'h1, CTRL_TWO_ADDR, 32'h2);
      poll(CTRL_TWO_ADDR, 32'h2, 32'h0);
      chk({scl_oe, sda_oe}, 2'h0, "lines kept");
      rd(EVT_STAT_ADDR, 32'h6, "collision events");
      chk(irq, 1'h1, "no irq");
      apb(1'h1, CTRL_TWO_ADDR, 32'h2);
      rd(CTRL_TWO_ADDR, 32'h0, "retry taken");
      chk(scl_oe, 1'h0, "clock driven");
      rival <= 1'h0;
      poll(STATUS_ADDR, 32'h10, 32'h10);
      apb(1'h1, EVT_STAT_ADDR, 32'h7);
      apb(1'h1, CTRL_TWO_ADDR, 32'h2);
      poll(CTRL_TWO_ADDR, 32'h2, 32'h0);
      rd(EVT_STAT_ADDR, 32'h1, "retry done");
      $display("test collide done");
   endtask : t_collide
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      t_regs();
      t_restart(8'h00);
      t_restart(8'h14);
      t_collide();
      conclude();
   end
endmodule : restart_master_tb
